/* design/brp_cfg.svh */
// constants for the block request processor
`ifndef BRP_CFG_SVH
`define BRP_CFG_SVH
`define BRP_T_READ 32'h0000_0000
`define BRP_T_WRITE 32'h0000_0001
`define BRP_T_SCSI 32'h0000_0002
`define BRP_T_SCSI_ALT 32'h0000_0003
`define BRP_T_FLUSH 32'h0000_0004
`define BRP_T_FLUSH_ALT 32'h0000_0005
`define BRP_BARRIER_BIT 31
`define BRP_SECTOR_SHIFT 9
`define BRP_SENSE_AREA_SIZE 32'h0000_0060
`define BRP_ST_OK 8'h00
`define BRP_ST_IO_FAULT 8'h01
`define BRP_ST_NOT_SUPPORTED 8'h02
`define BRP_FEAT_BARRIER 0
`define BRP_FEAT_WRITE_PROTECT 5
`define BRP_FEAT_SCSI 7
`define BRP_FEAT_FLUSH 9
`define BRP_A_CTRL 12'h000
`define BRP_A_FEAT 12'h004
`define BRP_A_STAT 12'h008
`define BRP_A_COUNT 12'h00c
`define BRP_A_LAST 12'h010
`define BRP_CTRL_RESET 32'h0000_0281
`endif

/* design/brp_pkg.sv */
// types for the block request processor
package brp_pkg;
  typedef enum logic [1:0] {
    BRP_OP_READ,
    BRP_OP_WRITE,
    BRP_OP_SCSI,
    BRP_OP_FLUSH
  } brp_op_e;
  typedef struct packed {
    logic [31:0] rtype;
    logic [31:0] prio;
    logic [63:0] sector;
    logic [31:0] cmd_len;
    logic [31:0] data_len;
    logic [31:0] sense_cap;
  } brp_req_s;
  typedef struct packed {
    logic [63:0] offset;
    logic [31:0] len;
    logic [31:0] cmd_len;
    brp_op_e op;
  } brp_cmd_s;
  typedef struct packed {
    logic ok;
    logic [31:0] moved;
    logic [31:0] sense_len;
  } brp_resp_s;
  typedef struct packed {
    logic [31:0] data_len;
    logic [31:0] sense_len;
    logic [31:0] residual;
    logic [7:0] status;
  } brp_done_s;
endpackage

/* design/brp_core.sv */
// block request processor: decode, ordering and completion
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "brp_cfg.svh"
module brp_core #(
  parameter int MAX_OUT = 4
) (
  // clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // request from the queue
  input wire logic req_valid_i,
  input wire brp_pkg::brp_req_s req_i,
  output logic req_ready_o,
  // command to storage
  output logic cmd_valid_o,
  output brp_pkg::brp_cmd_s cmd_o,
  input wire logic cmd_ready_i,
  // storage response, in issue order per slot
  input wire logic resp_valid_i,
  input wire brp_pkg::brp_resp_s resp_i,
  // result write-back
  output logic done_valid_o,
  output brp_pkg::brp_done_s done_o,
  output logic done_fields_o,
  output logic [31:0] done_prio_o
);

  // width of the pointers into the length ring; one bit at the least
  localparam int PW = (MAX_OUT > 1) ? $clog2(MAX_OUT) : 1;

  typedef enum logic [1:0] {
    BRP_S_IDLE,
    BRP_S_ISSUE,
    BRP_S_FIELDS,
    BRP_S_STATUS
  } brp_state_e;

  // decode outcome: 0 ok, 1 fault, 2 unsupported, 3 go to storage
  function automatic logic [1:0] brp_classify(input logic [31:0] t, input logic [31:0] f,
                                               output brp_pkg::brp_op_e op);
    logic [31:0] b;
    b = {1'b0, t[30:0]};
    op = brp_pkg::BRP_OP_READ;
    brp_classify = 2'd2;
    if (b == `BRP_T_READ) begin
      brp_classify = 2'd3;
    end else if (b == `BRP_T_WRITE) begin
      op = brp_pkg::BRP_OP_WRITE;
      brp_classify = f[`BRP_FEAT_WRITE_PROTECT] ? 2'd1 : 2'd3;
    end else if (b == `BRP_T_SCSI || b == `BRP_T_SCSI_ALT) begin
      op = brp_pkg::BRP_OP_SCSI;
      brp_classify = f[`BRP_FEAT_SCSI] ? 2'd3 : 2'd2;
    end else if (b == `BRP_T_FLUSH || b == `BRP_T_FLUSH_ALT) begin
      op = brp_pkg::BRP_OP_FLUSH;
      brp_classify = f[`BRP_FEAT_FLUSH] ? 2'd3 : 2'd2;
    end
  endfunction

  // next slot of the length ring, wrapping at MAX_OUT
  function automatic logic [PW-1:0] brp_wrap(input logic [PW-1:0] p);
    brp_wrap = (int'(p) == MAX_OUT - 1) ? '0 : p + PW'(1);
  endfunction

  brp_state_e state_reg, state_next;
  brp_pkg::brp_req_s cur_reg, cur_next;
  brp_pkg::brp_op_e op_reg, op_next;
  logic [31:0] feat_reg, feat_next;
  logic [31:0] count_reg, count_next;
  logic [7:0] last_reg, last_next;
  logic [$clog2(MAX_OUT+1)-1:0] out_reg, out_next;
  logic bar_reg, bar_next;
  logic req_ready_reg, req_ready_next;
  logic cmd_valid_reg, cmd_valid_next;
  brp_pkg::brp_cmd_s cmd_reg, cmd_next;
  logic done_valid_reg, done_valid_next;
  logic fields_reg, fields_next;
  brp_pkg::brp_done_s done_reg, done_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  brp_pkg::brp_op_e dec_op;
  logic [1:0] dec_cls;
  logic [31:0] moved_c;
  logic [31:0] sense_c;
  // local completion kept apart, so a storage answer cannot overwrite it
  brp_pkg::brp_done_s loc_reg, loc_next;
  // ring of requested lengths, one per command still at storage
  logic [PW-1:0] wp_reg, wp_next;
  logic [PW-1:0] rp_reg, rp_next;
  logic len_we;
  logic [31:0] len_head;
  logic [31:0] len_mem [MAX_OUT];

  // next-state logic
  always_comb begin
    state_next = state_reg;
    cur_next = cur_reg;
    op_next = op_reg;
    feat_next = feat_reg;
    count_next = count_reg;
    last_next = last_reg;
    out_next = out_reg;
    bar_next = bar_reg;
    req_ready_next = 1'b0;
    cmd_valid_next = cmd_valid_reg;
    cmd_next = cmd_reg;
    done_valid_next = 1'b0;
    fields_next = 1'b0;
    done_next = done_reg;
    prdata_next = prdata_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    loc_next = loc_reg;
    wp_next = wp_reg;
    rp_next = rp_reg;
    len_we = 1'b0;
    // oldest outstanding command, answered first by storage
    len_head = len_mem[rp_reg];
    dec_cls = brp_classify(cur_reg.rtype, feat_reg, dec_op);
    moved_c = resp_i.moved;
    // sense length capped by the 96-byte area
    sense_c = (resp_i.sense_len > `BRP_SENSE_AREA_SIZE) ? `BRP_SENSE_AREA_SIZE
              : resp_i.sense_len;
    // priority passed on as a hint only
    // storage responses are taken to arrive in the order the commands were issued
    // completion straight from storage
    if (resp_valid_i && out_reg != '0) begin
      out_next = out_reg - 1'b1;
      done_valid_next = 1'b1;
      fields_next = 1'b1;
      done_next.data_len = moved_c;
      done_next.sense_len = sense_c;
      // residual requested minus moved
      // the length of the request being answered, not the latest one taken
      done_next.residual = (resp_i.moved > len_head) ? 32'h0000_0000
                           : len_head - resp_i.moved;
      rp_next = brp_wrap(rp_reg);
      done_next.status = resp_i.ok ? `BRP_ST_OK : `BRP_ST_IO_FAULT;
      count_next = count_reg + 32'h0000_0001;
      last_next = done_next.status;
      if (out_reg == 1) begin
        bar_next = 1'b0;
      end
    end
    case (state_reg)
      BRP_S_IDLE: begin
        if (req_valid_i && !bar_reg && out_reg < MAX_OUT[$bits(out_reg)-1:0]
            && !done_valid_next) begin
          req_ready_next = 1'b1;
          cur_next = req_i;
          state_next = BRP_S_ISSUE;
        end
      end
      BRP_S_ISSUE: begin
        op_next = dec_op;
        if (feat_reg[`BRP_FEAT_BARRIER] && cur_reg.rtype[`BRP_BARRIER_BIT]
            && out_reg != '0) begin
          state_next = BRP_S_ISSUE;
        end else if (dec_cls != 2'd3) begin
          loc_next.data_len = 32'h0000_0000;
          loc_next.sense_len = 32'h0000_0000;
          loc_next.residual = cur_reg.data_len;
          loc_next.status = {6'h00, dec_cls};
          state_next = BRP_S_FIELDS;
        end else if (!cmd_valid_reg) begin
          cmd_valid_next = 1'b1;
          // byte offset is sector times 512 for read and write, zero for the other types
          cmd_next.offset = (dec_op == brp_pkg::BRP_OP_READ || dec_op == brp_pkg::BRP_OP_WRITE)
                            ? (cur_reg.sector << `BRP_SECTOR_SHIFT) : 64'h0000_0000_0000_0000;
          cmd_next.len = cur_reg.data_len;
          cmd_next.cmd_len = cur_reg.cmd_len;
          cmd_next.op = dec_op;
        end else if (cmd_ready_i) begin
          cmd_valid_next = 1'b0;
          out_next = out_next + 1'b1;
          // remember what was asked for, for the residual later
          len_we = 1'b1;
          wp_next = brp_wrap(wp_reg);
          bar_next = feat_reg[`BRP_FEAT_BARRIER] & cur_reg.rtype[`BRP_BARRIER_BIT];
          state_next = BRP_S_IDLE;
        end
      end
      BRP_S_FIELDS: begin
        if (!done_valid_next) begin
          fields_next = 1'b1;
          done_next = loc_reg;
          state_next = BRP_S_STATUS;
        end
      end
      BRP_S_STATUS: begin
        // storage answers take the write-back port first; wait for a free cycle
        if (!done_valid_next) begin
          done_valid_next = 1'b1;
          done_next = loc_reg;
          count_next = count_reg + 32'h0000_0001;
          last_next = loc_reg.status;
          state_next = BRP_S_IDLE;
        end
      end
      default: begin
        state_next = BRP_S_IDLE;
      end
    endcase
    // apb access phase answered in one cycle
    if (psel_i && penable_i && !pready_reg) begin
      pready_next = 1'b1;
      prdata_next = 32'h0000_0000;
      if (paddr_i == `BRP_A_CTRL) begin
        prdata_next = feat_reg;
      end else if (paddr_i == `BRP_A_FEAT) begin
        prdata_next = feat_reg;
      end else if (paddr_i == `BRP_A_STAT) begin
        prdata_next = {28'h000_0000, bar_reg, out_reg != '0, state_reg};
      end else if (paddr_i == `BRP_A_COUNT) begin
        prdata_next = count_reg;
      end else if (paddr_i == `BRP_A_LAST) begin
        prdata_next = {24'h00_0000, last_reg};
      end else begin
        pslverr_next = 1'b1;
      end
    end
    // write lands on the edge that completes the transfer, pready seen high
    if (psel_i && penable_i && pready_reg && pwrite_i) begin
      if (paddr_i == `BRP_A_CTRL) begin
        feat_next = pwdata_i;
      end
    end
  end

  // state registers, frozen while en_i is low
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= BRP_S_IDLE;
      cur_reg <= '0;
      op_reg <= brp_pkg::BRP_OP_READ;
      feat_reg <= `BRP_CTRL_RESET;
      count_reg <= 32'h0000_0000;
      last_reg <= 8'h00;
      out_reg <= '0;
      bar_reg <= 1'b0;
      req_ready_reg <= 1'b0;
      cmd_valid_reg <= 1'b0;
      cmd_reg <= '0;
      done_valid_reg <= 1'b0;
      fields_reg <= 1'b0;
      done_reg <= '0;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      loc_reg <= '0;
      wp_reg <= '0;
      rp_reg <= '0;
    end else if (en_i) begin
      state_reg <= state_next;
      cur_reg <= cur_next;
      op_reg <= op_next;
      feat_reg <= feat_next;
      count_reg <= count_next;
      last_reg <= last_next;
      out_reg <= out_next;
      bar_reg <= bar_next;
      req_ready_reg <= req_ready_next;
      cmd_valid_reg <= cmd_valid_next;
      cmd_reg <= cmd_next;
      done_valid_reg <= done_valid_next;
      fields_reg <= fields_next;
      done_reg <= done_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      loc_reg <= loc_next;
      wp_reg <= wp_next;
      rp_reg <= rp_next;
    end
  end

  // length ring, written as a command is handed to storage
  always_ff @(posedge clk_i) begin
    if (en_i && len_we) begin
      len_mem[wp_reg] <= cur_reg.data_len;
    end
  end

  // outputs straight from flops
  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign req_ready_o = req_ready_reg;
  assign cmd_valid_o = cmd_valid_reg;
  assign cmd_o = cmd_reg;
  assign done_valid_o = done_valid_reg;
  assign done_fields_o = fields_reg;
  assign done_o = done_reg;
  assign done_prio_o = cur_reg.prio;

endmodule

/* dv/brp_core_properties.sv */
// checker for the block request processor ports
`timescale 1ns/1ps
module brp_core_properties (
  // watched ports
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_ready_o,
  input wire brp_pkg::brp_req_s req_i,
  input wire logic cmd_valid_o,
  input wire brp_pkg::brp_cmd_s cmd_o,
  input wire logic cmd_ready_i,
  input wire logic resp_valid_i,
  input wire brp_pkg::brp_resp_s resp_i,
  input wire logic done_valid_o,
  input wire logic done_fields_o,
  input wire brp_pkg::brp_done_s done_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [7:0] outs_reg, outs_next;
  logic bar_reg, bar_next;
  logic bwait_reg, bwait_next;
  logic [2:0] lw_reg, lw_next, lr_reg, lr_next;
  logic [31:0] len_head;
  logic [31:0] lens [8];
  // requests in flight, barrier in flight, barrier not yet issued
  always_comb begin
    outs_next = outs_reg + 8'(req_ready_o) - 8'(done_valid_o);
    bar_next = (bar_reg || (req_ready_o && req_i.rtype[31]))
               && !(done_valid_o && outs_reg == 8'h01);
    bwait_next = (bwait_reg || (req_ready_o && req_i.rtype[31])) && !cmd_valid_o
                 && !(done_fields_o && !done_valid_o);
    lw_next = lw_reg + 3'(cmd_valid_o && cmd_ready_i);
    lr_next = lr_reg + 3'(resp_valid_i);
    len_head = lens[lr_reg];
  end
  // helper registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      outs_reg <= 8'h00;
      bar_reg <= 1'b0;
      bwait_reg <= 1'b0;
      lw_reg <= 3'h0;
      lr_reg <= 3'h0;
    end else begin
      outs_reg <= outs_next;
      bar_reg <= bar_next;
      bwait_reg <= bwait_next;
      lw_reg <= lw_next;
      lr_reg <= lr_next;
    end
  end
  // requested length of every command handed to storage
  always_ff @(posedge clk_i) begin
    if (cmd_valid_o && cmd_ready_i) begin
      lens[lw_reg] <= cmd_o.len;
    end
  end
  sequence s_issue;
    $rose(cmd_valid_o);
  endsequence
  sequence s_local;
    ##[1:4] done_fields_o ##1 (done_valid_o && done_o.status == 8'h02);
  endsequence
  a_read_issue: assert property (
    req_ready_o && req_i.rtype == 32'h0000_0000 ##1 s_issue |->
    cmd_o.op == brp_pkg::BRP_OP_READ && cmd_o.offset == {$past(req_i.sector[54:0]), 9'h000})
    else $error("read command wrong");
  a_scsi_issue: assert property (
    req_ready_o && req_i.rtype[30:1] == 30'h1 ##1 s_issue |->
    cmd_o.op == brp_pkg::BRP_OP_SCSI && cmd_o.cmd_len == $past(req_i.cmd_len))
    else $error("scsi command wrong");
  a_unknown_type: assert property (
    req_ready_o && !req_i.rtype[31] && req_i.rtype > 32'h0000_0005 |-> s_local)
    else $error("unknown type not refused");
  a_resp_done: assert property (
    resp_valid_i |=> done_valid_o && done_fields_o && done_o.status == {7'h0, !$past(resp_i.ok)})
    else $error("storage completion wrong");
  a_resid_calc: assert property (
    resp_valid_i |=> done_o.residual == $past(len_head) - $past(resp_i.moved))
    else $error("residual wrong");
  a_fields_first: assert property (
    done_valid_o |-> done_fields_o || $past(done_fields_o))
    else $error("status before fields");
  a_bar_drain: assert property (
    bwait_reg && s_issue |-> outs_reg == 8'h01)
    else $error("barrier taken early");
  a_bar_block: assert property (
    bar_reg |-> !req_ready_o)
    else $error("request passed barrier");
endmodule
bind brp_core brp_core_properties u_props (.*);

/* dv/brp_store_model.sv */
// storage model answering commands in issue order
`timescale 1ns/1ps
module brp_store_model (
  // clock, reset and pace
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic slow_i,
  // command and response
  input wire logic cmd_valid_i,
  input wire brp_pkg::brp_cmd_s cmd_i,
  output logic cmd_ready_o,
  output logic resp_valid_o,
  output brp_pkg::brp_resp_s resp_o
);
  logic [64:0] pend[$];
  logic [1:0] tick;
  // moves half the length; length 0xbad is answered as a fault
  // scsi commands report their length as sense bytes, to reach the cap
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend.delete();
      tick <= 2'h0;
      cmd_ready_o <= 1'b0;
      resp_valid_o <= 1'b0;
      resp_o <= '0;
    end else begin
      tick <= tick + 2'h1;
      cmd_ready_o <= cmd_valid_i && !cmd_ready_o && (!slow_i || tick == 2'h3);
      if (cmd_valid_i && cmd_ready_o)
        pend.push_back({cmd_i.len != 32'h0000_0bad, cmd_i.len >> 1,
                        (cmd_i.op == brp_pkg::BRP_OP_SCSI) ? cmd_i.len : 32'h0000_0000});
      resp_valid_o <= pend.size() > 0 && tick[0];
      if (pend.size() > 0 && tick[0])
        resp_o <= pend.pop_front();
      else
        resp_o <= ~resp_o;
    end
  end
endmodule

/* dv/block_request_processor_test.sv */
// self-checking bench for the block request processor
`timescale 1ns/1ps
`include "brp_cfg.svh"
module block_request_processor_test;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic en_i = 1'b1;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, req_valid_i = 1'b0, slow = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, done_prio_o, rnd = 32'h543d_1dcc;
  logic pready_o, pslverr_o, req_ready_o, cmd_valid_o, cmd_ready_i, resp_valid_i;
  logic done_valid_o, done_fields_o;
  brp_pkg::brp_req_s req_i = '0;
  brp_pkg::brp_cmd_s cmd_o;
  brp_pkg::brp_resp_s resp_i;
  brp_pkg::brp_done_s done_o;
  brp_pkg::brp_done_s exp_q[$];
  logic [32:0] rd;
  int fail_count = 0, n_checks = 0;
  brp_core i_dut (.*);
  brp_store_model i_store (.clk_i(clk_i), .rst_n_i(rst_n_i), .slow_i(slow),
    .cmd_valid_i(cmd_valid_o), .cmd_i(cmd_o), .cmd_ready_o(cmd_ready_i),
    .resp_valid_o(resp_valid_i), .resp_o(resp_i));
  always #20 clk_i = ~clk_i;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic wrap_up;
    // completions still awaited count as lost
    if (exp_q.size() != 0) fail_count++;
    if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk_word(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t apb got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_done(input brp_pkg::brp_done_s exp);
    n_checks++;
    // deprecated data length left unchecked, as the driver ignores it
    if ({done_o.status, done_o.sense_len, done_o.residual}
        !== {exp.status, exp.sense_len, exp.residual}) begin
      fail_count++;
      $display("CHECK FAILED %0t done got %h exp %h", $time, done_o, exp);
    end
  endtask
  // one apb transfer, result left in rd
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = {pslverr_o, prdata_o};
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic drain;
    for (int i = 0; i < 300 && exp_q.size() != 0; i++) @(posedge clk_i);
  endtask
  // one request; local completions are awaited so order stays known
  task automatic send(input logic [31:0] t, input logic [31:0] l, input logic [7:0] st,
                      input logic lcl);
    rnd = xs(rnd);
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    // small sector, zero unless read or write
    // header, results, sense and status kept as separate fields
    req_i <= '{t, rnd, (t[30:0] < 2) ? {36'h0, rnd[27:0]} : 64'h0, 32'h0000_000c, l,
               `BRP_SENSE_AREA_SIZE};
    // storage moves half; scsi sense is its length, capped at the sense area
    exp_q.push_back('{lcl ? 32'h0000_0000 : l >> 1,
                      (!lcl && t[30:1] == 30'h0000_0001) ? ((l > `BRP_SENSE_AREA_SIZE) ?
                      `BRP_SENSE_AREA_SIZE : l) : 32'h0000_0000,
                      lcl ? l : l - (l >> 1), st});
    do @(posedge clk_i); while (req_ready_o !== 1'b1);
    req_valid_i <= 1'b0;
    chk_word({1'b0, done_prio_o}, {1'b0, rnd});
    if (lcl) drain();
  endtask
  // completion monitor
  always @(posedge clk_i)
    if (done_valid_o === 1'b1) begin
      if (exp_q.size() == 0) chk_done('x);
      else chk_done(exp_q.pop_front());
    end
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    wrap_up();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    apb(1'b0, `BRP_A_CTRL, 32'h0000_0000);
    chk_word(rd, {1'b0, `BRP_CTRL_RESET});
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk_word(rd, {1'b1, 32'h0000_0000});
    for (int i = 0; i < 12; i++) begin
      slow <= i > 5;
      send(i == 4 ? 32'h8000_0000 : {31'h0, i[0]}, {20'h0, rnd[11:1], 1'b0}, 8'h00, 1'b0);
    end
    for (int t = 2; t < 6; t++) send(32'(t), 32'((6 - t) << 5), 8'h00, 1'b0);
    send(32'h0000_0000, 32'h0000_0bad, 8'h01, 1'b0);
    drain();
    // freeze a while with nothing in flight; counts must survive it
    en_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    en_i <= 1'b1;
    apb(1'b0, `BRP_A_COUNT, 32'h0000_0000);
    chk_word(rd, {1'b0, 32'h0000_0011});
    send(32'h0000_0006, 32'h0000_0010, 8'h02, 1'b1);
    send(32'h7fff_ffff, 32'h0000_0010, 8'h02, 1'b1);
    apb(1'b1, `BRP_A_CTRL, 32'h0000_0221);
    apb(1'b0, `BRP_A_FEAT, 32'h0000_0000);
    chk_word(rd, {1'b0, 32'h0000_0221});
    send(32'h0000_0001, 32'h0000_0020, 8'h01, 1'b1);
    send(32'h0000_0002, 32'h0000_0020, 8'h02, 1'b1);
    drain();
    wrap_up();
  end
endmodule
